/* File: rtl/sbs_sram_port.sv */
// control side of a pipelined burst synchronous sram, seen from the memory
// assumes the bus master drives pins synchronous to core_clk; the data
// wire is resolved outside from dq_out and dq_oe
`timescale 1ns/1ps
`include "sbs_consts.svh"

// Summary of operation
// - sample all pins on clock, except three
// - capture address when selected and strobed
// - drive data only enabled and oe active
// - master select blocks processor strobe
// - second select high, third low, when sampled
// - processor strobe loads address or deselects
// - controller strobe loads address or deselects
// - advance high holds current burst address
// - global write writes every byte lane
// - lane enables count only when qualifier low
// - write exactly lanes whose enables are low
// - order select high interleaved, low linear
// - snooze held as long as input high
// - snooze deselects, ignores pins, floats outputs
// - asynchronous oe drives pins only in reads
// - write when global or qualified lane low
// - address edge, output register, next edge
// - advance only when controller strobe high and processor strobe high or blocked
module sbs_sram_port
  import sbs_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [`SBS_ADDR_W-1:0] addr,
  input  wire sbs_strobe_s            strobe,
  input  wire sbs_write_s             wr_ctl,
  input  wire logic                   output_enable_n,
  input  wire logic                   burst_order_sel,
  input  wire logic                   snooze_req,
  input  wire logic [`SBS_DATA_W-1:0] dq_in,
  output logic      [`SBS_DATA_W-1:0] dq_out,
  output logic                        dq_oe
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sbs_op_e                  op;
  logic [`SBS_ADDR_W-1:0]   base_addr;
  logic [`SBS_BURST_W-1:0]  count;
  logic                     rd_pend;
  logic                     rd_valid;

  // ----------------------------------------------------------------------
  // select and strobe decode; snooze masks every sampled pin
  // ----------------------------------------------------------------------
  wire awake     = ~snooze_req;
  wire ps_hit    = awake & ~strobe.processor_addr_strobe_n
                 & ~strobe.master_select_n;
  wire cs_hit    = awake & ~strobe.controller_addr_strobe_n;
  wire all_sel   = ~strobe.master_select_n & strobe.second_select_hi
                 & ~strobe.third_select_n;
  wire strobed   = ps_hit | cs_hit;
  wire start     = strobed & all_sel;
  wire deselect  = strobed & ~all_sel;
  wire cont      = awake & ~strobed & (op != SBS_OP_IDLE);
  wire adv_go    = cont & ~strobe.burst_advance_n;

  // ----------------------------------------------------------------------
  // write decode: global write wins, lanes need the qualifier
  // ----------------------------------------------------------------------
  wire                  lane_any  = ~&wr_ctl.lane_write_n;
  wire [`SBS_LANES-1:0] lane_mask =
    ~wr_ctl.global_write_n         ? `SBS_ALL_LANES :
    ~wr_ctl.byte_write_qualifier_n ? ~wr_ctl.lane_write_n :
                                     `SBS_NO_LANES;
  wire                  wr_req    = ~wr_ctl.global_write_n
                                  | (~wr_ctl.byte_write_qualifier_n & lane_any);

  // a processor-strobed start ignores write enables, so it always reads
  wire start_wr = start & ~ps_hit & strobe.processor_addr_strobe_n & wr_req;
  wire cont_wr  = cont & wr_req;
  wire do_wr    = start_wr | cont_wr;
  wire do_rd    = (start & ~start_wr) | (cont & ~wr_req);

  // ----------------------------------------------------------------------
  // burst address: interleaved xors the count, linear adds it
  // ----------------------------------------------------------------------
  wire [`SBS_BURST_W-1:0] next_count = adv_go ? count + 2'h1 : count;
  wire [`SBS_BURST_W-1:0] low_bits   = burst_order_sel
    ? base_addr[`SBS_BURST_W-1:0] ^ next_count
    : base_addr[`SBS_BURST_W-1:0] + next_count;
  wire [`SBS_ADDR_W-1:0]  burst_addr =
    {base_addr[`SBS_ADDR_W-1:`SBS_BURST_W], low_bits};
  wire [`SBS_ADDR_W-1:0]  eff_addr   = start ? addr : burst_addr;

  // address held for the array read; it lags the access by one edge
  logic [`SBS_ADDR_W-1:0] rd_addr;

  // ----------------------------------------------------------------------
  // access state; a deselect or snooze ends any burst
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst || snooze_req || deselect)
      op <= SBS_OP_IDLE;
    else if (start || cont)
      op <= do_wr ? SBS_OP_WRITE : SBS_OP_READ;
  end

  // burst base and counter; held unless a start or an advance
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      base_addr <= '0;
      count     <= '0;
    end
    else if (start)
    begin
      base_addr <= addr;
      count     <= '0;
    end
    else if (adv_go)
      count <= next_count;
  end

  // read pipeline: address edge, array register edge, then drive
  always_ff @(posedge core_clk)
  begin
    if (rst || snooze_req)
    begin
      rd_pend  <= 1'b0;
      rd_valid <= 1'b0;
      rd_addr  <= '0;
    end
    else
    begin
      rd_pend  <= do_rd;
      rd_valid <= rd_pend & ~do_wr;
      rd_addr  <= eff_addr;
    end
  end

  // ----------------------------------------------------------------------
  // array
  // ----------------------------------------------------------------------
  sbs_mem u_mem (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_addr  (eff_addr),
    .wr_lane  (do_wr ? lane_mask : `SBS_NO_LANES),
    .wr_data  (dq_in),
    .rd_addr  (rd_addr),
    .rd_data  (dq_out)
  );

  // output enable acts without the clock, so it cannot come from a
  // flip-flop; snooze floats the pins whatever oe says
  assign dq_oe = rd_valid & ~output_enable_n & ~snooze_req;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_addr_capture: assert property (
    @(posedge core_clk) disable iff (rst)
    start |=> (base_addr == $past(addr)) && (count == 2'h0))
    else $error("address not captured on a selected strobe");

  a_hold_suspend: assert property (
    @(posedge core_clk) disable iff (rst)
    (cont && strobe.burst_advance_n) |=> $stable(count) && $stable(base_addr))
    else $error("burst address moved while advance was high");

  a_adv_cause: assert property (
    @(posedge core_clk) disable iff (rst)
    !$stable(count) |-> $past(adv_go) || $past(start) || $past(rst))
    else $error("burst counter moved without advance");

  a_oe_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    dq_oe |-> !output_enable_n && rd_valid && (op != SBS_OP_IDLE || $past(rd_pend)))
    else $error("data driven outside an enabled read");

  a_snooze_float: assert property (
    @(posedge core_clk) disable iff (rst)
    snooze_req |-> !dq_oe ##1 (op == SBS_OP_IDLE) && !rd_valid)
    else $error("outputs or state active during snooze");

  a_global_write: assert property (
    @(posedge core_clk) disable iff (rst)
    !wr_ctl.global_write_n |-> lane_mask == `SBS_ALL_LANES && wr_req)
    else $error("global write did not select all lanes");

  a_lane_exact: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_ctl.global_write_n && !wr_ctl.byte_write_qualifier_n)
      |-> lane_mask == ~wr_ctl.lane_write_n && wr_req == lane_any)
    else $error("lane write mask wrong");

  a_qual_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_ctl.global_write_n && wr_ctl.byte_write_qualifier_n) |-> !wr_req)
    else $error("write decoded with qualifier high");

  a_read_latency: assert property (
    @(posedge core_clk) disable iff (rst || snooze_req)
    (do_rd ##1 !do_wr) |=> rd_valid)
    else $error("read data not presented two edges after address");

  a_deselect: assert property (
    @(posedge core_clk) disable iff (rst)
    deselect |=> (op == SBS_OP_IDLE) && !rd_pend)
    else $error("deselect did not end the burst");

  // advance steps the array address from the stored start and next_count, not from the previous address
  a_order_inter: assert property (
    @(posedge core_clk) disable iff (rst)
    (adv_go && burst_order_sel) |-> eff_addr[1:0] == (base_addr[1:0] ^ 2'(count + 2'h1)))
    else $error("interleaved order wrong");

  a_order_linear: assert property (
    @(posedge core_clk) disable iff (rst)
    (adv_go && !burst_order_sel) |-> eff_addr[1:0] == 2'(base_addr[1:0] + count + 2'h1))
    else $error("linear order wrong");

endmodule : sbs_sram_port

/* File: shared/sbs_consts.svh */
// constants of the burst sram port: widths, depth and burst counter layout
// assumes nothing; definitions only, included by bare name
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

// ----------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------
`define SBS_ADDR_W   17
`define SBS_LANES    4
`define SBS_LANE_W   9
`define SBS_DATA_W   36
`define SBS_DEPTH    131072

// ----------------------------------------------------------------------
// burst counter: low address bits that wrap within a group of four
// ----------------------------------------------------------------------
`define SBS_BURST_W  2
`define SBS_ALL_LANES 4'hf
`define SBS_NO_LANES  4'h0

`endif

/* File: shared/sbs_pkg.sv */
// types shared by the burst sram port and its array
// assumes sbs_consts.svh sits on the include path
`include "sbs_consts.svh"

package sbs_pkg;

  // ----------------------------------------------------------------------
  // pin groups sampled on the clock
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic master_select_n;
    logic second_select_hi;
    logic third_select_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
  } sbs_strobe_s;

  typedef struct packed {
    logic                    global_write_n;
    logic                    byte_write_qualifier_n;
    logic [`SBS_LANES-1:0]   lane_write_n;
  } sbs_write_s;

  // ----------------------------------------------------------------------
  // kind of access the port is currently carrying
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SBS_OP_IDLE,
    SBS_OP_READ,
    SBS_OP_WRITE
  } sbs_op_e;

endpackage : sbs_pkg

/* File: rtl/sbs_mem.sv */
// storage array of the burst sram port, byte-lane writes, registered read
// assumes one clock; read data appear one edge after the address is held
`timescale 1ns/1ps
`include "sbs_consts.svh"

module sbs_mem
  import sbs_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [`SBS_ADDR_W-1:0] wr_addr,
  input  wire logic [`SBS_LANES-1:0]  wr_lane,
  input  wire logic [`SBS_DATA_W-1:0] wr_data,
  input  wire logic [`SBS_ADDR_W-1:0] rd_addr,
  output logic      [`SBS_DATA_W-1:0] rd_data
);

  // ----------------------------------------------------------------------
  // one storage slice per byte lane, each with its own write port and read
  // register, so no two processes ever write the same array
  // ----------------------------------------------------------------------
  genvar gl;
  generate
    for (gl = 0; gl < `SBS_LANES; gl = gl + 1)
    begin : g_lane
      logic [`SBS_LANE_W-1:0] lane_store [0:`SBS_DEPTH-1];

      // lane write on the access edge; reset does not touch stored contents
      always_ff @(posedge core_clk)
      begin
        if (wr_lane[gl])
          lane_store[wr_addr] <= wr_data[gl*`SBS_LANE_W +: `SBS_LANE_W];
      end

      // lane read register, cleared on reset so the data pins start defined
      always_ff @(posedge core_clk)
      begin
        if (rst)
          rd_data[gl*`SBS_LANE_W +: `SBS_LANE_W] <= '0;
        else
          rd_data[gl*`SBS_LANE_W +: `SBS_LANE_W] <= lane_store[rd_addr];
      end
    end
  endgenerate

endmodule : sbs_mem

/* File: sim/sbs_master_model.sv */
// bus master model of the burst sram port: drives every pin of the port
// assumes the bench calls cyc once per clock cycle and sets the mode flags
`timescale 1ns/1ps
`include "sbs_consts.svh"

module sbs_master_model
  import sbs_pkg::*;
(
  input  wire logic                   core_clk,
  output logic      [`SBS_ADDR_W-1:0] addr,
  output sbs_strobe_s                 strobe,
  output sbs_write_s                  wr_ctl,
  output logic                        output_enable_n,
  output logic                        burst_order_sel,
  output logic                        snooze_req,
  output logic      [`SBS_DATA_W-1:0] dq_in
);
  logic ord_want = 1'b1;  // 1 interleaved, 0 linear
  logic oe_off   = 1'b1;  // output enable held high
  logic zz_want  = 1'b0;  // snooze level

  // parked: deselected, no strobe, no write
  initial
  begin
    addr            = '0;
    strobe          = 6'h37;
    wr_ctl          = 6'h3f;
    output_enable_n = 1'b1;
    burst_order_sel = 1'b1;
    snooze_req      = 1'b0;
    dq_in           = '0;
  end

  // one cycle: pins change at the falling edge and hold through the rising edge
  task automatic cyc(input logic [2:0] sel, input logic p_n, input logic c_n,
                     input logic adv_n, input sbs_write_s w,
                     input logic [`SBS_ADDR_W-1:0] a, input logic [`SBS_DATA_W-1:0] d);
    logic wr;
    wr = !w.global_write_n || (!w.byte_write_qualifier_n && w.lane_write_n != `SBS_ALL_LANES);
    @(negedge core_clk);
    addr            <= a;
    strobe          <= {sel, p_n, c_n, adv_n};
    wr_ctl          <= w;
    output_enable_n <= wr | oe_off;             // no bus fight on writes
    burst_order_sel <= ord_want;
    snooze_req      <= zz_want;
    dq_in           <= wr ? d : ~dq_in;         // released lines toggle, never hold
    @(posedge core_clk);
  endtask : cyc

endmodule : sbs_master_model

/* File: sim/sync_burst_sram_port_tb.sv */
// self-checking bench of the burst sram port driven by a bus master model
// assumes the array sits inside sbs_sram_port and starts unwritten
`timescale 1ns/1ps
`include "sbs_consts.svh"

module sync_burst_sram_port_tb;
  import sbs_pkg::*;

  localparam logic [2:0] SEL_ON = 3'b010;  // master low, second high, third low
  logic                   core_clk = 1'b0;
  logic                   rst      = 1'b1;
  logic [15:0]            seed     = 16'h663c;
  logic [`SBS_ADDR_W-1:0] base;
  logic [`SBS_DATA_W-1:0] mem [logic [`SBS_ADDR_W-1:0]];  // shadow of the array
  logic [`SBS_DATA_W-1:0] exp_q [$];                      // words owed on the bus
  logic [2:0]             bad [4] = '{3'b000, 3'b011, 3'b110, 3'b000};
  int                     err_total = 0;
  int                     compares  = 0;
  wire  [`SBS_ADDR_W-1:0] addr;
  wire  sbs_strobe_s      strobe;
  wire  sbs_write_s       wr_ctl;
  wire                    output_enable_n;
  wire                    burst_order_sel;
  wire                    snooze_req;
  wire  [`SBS_DATA_W-1:0] dq_in;
  wire  [`SBS_DATA_W-1:0] dq_out;
  wire                    dq_oe;

  always #12.5 core_clk = ~core_clk;

  sbs_master_model i_mst (.core_clk(core_clk), .addr(addr), .strobe(strobe), .wr_ctl(wr_ctl),
    .output_enable_n(output_enable_n), .burst_order_sel(burst_order_sel),
    .snooze_req(snooze_req), .dq_in(dq_in));

  sbs_sram_port i_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .strobe(strobe),
    .wr_ctl(wr_ctl), .output_enable_n(output_enable_n), .burst_order_sel(burst_order_sel),
    .snooze_req(snooze_req), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // k-th word of a burst from a, in the order now selected
  function automatic logic [`SBS_ADDR_W-1:0] burst_addr(input logic [`SBS_ADDR_W-1:0] a,
                                                           input logic [1:0] k);
    return {a[`SBS_ADDR_W-1:2], i_mst.ord_want ? a[1:0] ^ k : a[1:0] + k};
  endfunction : burst_addr

  task automatic check(input string what, input logic [`SBS_DATA_W-1:0] seen,
                       input logic [`SBS_DATA_W-1:0] want);
    compares++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // deselect cycles; they also let the read pipeline drain
  task automatic idle(input int n);
    repeat (n) i_mst.cyc(3'b110, 1'b1, 1'b0, 1'b1, 6'h3f, base, '0);
  endtask : idle

  // four-beat burst started by the controller strobe, same enables on every beat
  task automatic wr_burst(input logic [`SBS_ADDR_W-1:0] a, input sbs_write_s w);
    logic [`SBS_DATA_W-1:0] d;
    logic [`SBS_ADDR_W-1:0] b;
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      d = {seed[3:0], seed, ~seed};
      b = burst_addr(a, k[1:0]);
      for (int l = 0; l < 4; l++)
        if (!w.global_write_n || (!w.byte_write_qualifier_n && !w.lane_write_n[l]))
          mem[b][l*9 +: 9] = d[l*9 +: 9];
      i_mst.cyc(SEL_ON, 1'b1, k != 0, 1'b0, w, a, d);
    end
    idle(3);
  endtask : wr_burst

  // start, advance, suspend, advance, advance; a processor start carries write enables and still reads
  task automatic rd_burst(input logic [`SBS_ADDR_W-1:0] a, input logic p);
    int ks [5] = '{0, 1, 1, 2, 3};
    for (int i = 0; i < 5; i++)
    begin
      exp_q.push_back(mem[burst_addr(a, ks[i][1:0])]);
      i_mst.cyc(SEL_ON, !(p && i == 0), !(!p && i == 0), i == 2,
                (p && i == 0) ? 6'h0f : 6'h3f, a, '0);
    end
    idle(3);
  endtask : rd_burst

  // watcher: each driven word must match the oldest note
  always @(negedge core_clk)
  begin
    check("oe_gate", 36'(dq_oe & (output_enable_n | snooze_req)), '0);
    if (dq_oe === 1'b1 && exp_q.size() == 0)
      check("unsent_read", 36'h1, '0);
    else if (dq_oe === 1'b1)
      check("dq_out", dq_out, exp_q.pop_front());
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst <= 1'b0;
    // both burst orders; full, two-lane, qualifier-high and no-lane writes
    for (int m = 0; m < 2; m++)
    begin
      seed = lfsr(seed);
      base = {seed, 1'b1} ^ 17'(m);
      i_mst.ord_want = m[0];
      i_mst.oe_off = 1'b1;
      wr_burst(base, 6'h1f);
      wr_burst(base, 6'h2a);
      wr_burst(base, 6'h30);
      wr_burst(base, 6'h2f);
      i_mst.oe_off = 1'b0;
      rd_burst(base ^ 17'(m + 1), m[0]);
    end
    // partial selects and a blocked processor strobe must start nothing
    for (int j = 0; j < 4; j++)
    begin
      i_mst.cyc(bad[j], j < 2, j >= 2, 1'b0, 6'h3f, base, '0);
      i_mst.cyc(SEL_ON, 1'b1, 1'b1, 1'b0, 6'h3f, base, '0);
    end
    idle(3);
    // snooze: accesses drained first, write and read ignored, data kept
    i_mst.zz_want = 1'b1;
    i_mst.cyc(SEL_ON, 1'b1, 1'b0, 1'b0, 6'h1f, base, ~mem[base]);
    i_mst.cyc(SEL_ON, 1'b0, 1'b1, 1'b0, 6'h3f, base, '0);
    idle(2);
    i_mst.zz_want = 1'b0;
    idle(3);
    rd_burst(base, 1'b0);
    check("pending_reads", 36'(exp_q.size()), '0);
    final_report();
  end

endmodule : sync_burst_sram_port_tb
